// ===== pkg/svd_pkg.sv
// Package: register map, field layout and synchroniser depth for the voltage detector
package svd_pkg;
    // Register indices (word address = index)
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_MASK = 4'h2;
    localparam logic [3:0] ADDR_FLAGS = 4'h3;

    // Control register fields
    localparam int BIT_DIRECTION = 7;
    localparam int BIT_UNUSED = 6;
    localparam int BIT_REF_STABLE = 5;
    localparam int BIT_ENABLE = 4;
    localparam int LEVEL_MSB = 3;
    localparam int LEVEL_LSB = 0;
    localparam logic [3:0] LEVEL_EXTERNAL = 4'hF;
    localparam logic [3:0] LEVEL_RESET = 4'h5;
    localparam logic [7:0] CONTROL_RESET = 8'h05;
    localparam logic [7:0] CONTROL_WMASK = 8'h9F;

    // Flag and status layout
    localparam int BIT_DETECT = 0;
    localparam int BIT_STABLE_EVT = 1;
    localparam logic [1:0] EVENT_NONE = 2'h0;

    // Synchroniser depth
    localparam int SYNC_STAGES = 2;
endpackage

// ===== pkg/svd_sync_if.sv
// Interface: raw analog indications and their synchronised copies
`timescale 1ns/10ps
interface svd_sync_if;
    logic raw_trip;
    logic raw_settled;
    logic trip;
    logic settled;
    modport sync (input raw_trip, input raw_settled, output trip, output settled);
    modport core (output raw_trip, output raw_settled, input trip, input settled);
endinterface

// ===== verilog/svd_sync.sv
// Two-stage synchronisers for the comparator and reference-settled inputs
`timescale 1ns/10ps
module svd_sync
    import svd_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Signals
    svd_sync_if.sync sig
);
    logic [SYNC_STAGES-1:0] stage_trip;
    logic [SYNC_STAGES-1:0] stage_settled;
    logic [SYNC_STAGES-1:0] next_stage_trip;
    logic [SYNC_STAGES-1:0] next_stage_settled;

    always_comb
    begin
        next_stage_trip = {stage_trip[SYNC_STAGES-2:0], sig.raw_trip};
        next_stage_settled = {stage_settled[SYNC_STAGES-2:0], sig.raw_settled};
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            stage_trip <= '0;
            stage_settled <= '0;
        end
        else
        begin
            stage_trip <= next_stage_trip;
            stage_settled <= next_stage_settled;
        end
    end

    assign sig.trip = stage_trip[SYNC_STAGES-1];
    assign sig.settled = stage_settled[SYNC_STAGES-1];
endmodule

// ===== verilog/svd_ctrl.sv
// Control, status and interrupt logic of the supply voltage detector
//
// Summary of operation
// - Direction 1: supply at or above trip point is an event.
// - Direction 0: supply at or below trip point is an event.
// - Reference-stable bit is read-only, set once detector has settled.
// - Enable powers the analog detector; clear turns it off, no events.
// - Each enable restarts settling; stable bit clear until it ends.
// - No detect flag before the stable bit is set.
// - Settling time comes from analog reference, not a clock count.
// - Comparator crossing in chosen direction sets the detect flag.
// - Trip level is the 4-bit low field, choosing one of fifteen taps or the external input.
// - Code 0000 lowest threshold, 1110 highest, monotonic in between.
// - Code 1111 routes external trip input to the comparator.
// - Bit 6 reads zero, writes ignored.
// - Detector works while asleep; a crossing sets flag and wakes.
// - Reset returns control to reset state, detector off.
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module svd_ctrl
    import svd_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Analog side
    input wire logic comparator_out,
    input wire logic reference_settled,
    output logic analog_power,
    output logic [3:0] tap_select,
    output logic external_select,
    output logic direction_select,
    // Sleep and interrupt
    output logic wake,
    output logic irq
);
    // ==========================================================
    // Synchronisers
    svd_sync_if sig ();
    assign sig.raw_trip = comparator_out;
    assign sig.raw_settled = reference_settled;

    svd_sync i_svd_sync
    (
        .clock(clock),
        .rst(rst),
        .sig(sig)
    );

    // ==========================================================
    // Detector state machine
    typedef enum logic [1:0]
    {
        SVD_OFF = 2'b00,
        SVD_SETTLING = 2'b01,
        SVD_ARMED = 2'b11
    } svd_state_t;

    svd_state_t state;
    svd_state_t next_state;
    logic [7:0] control;
    logic [7:0] next_control;
    logic [1:0] flags;
    logic [1:0] next_flags;
    logic [1:0] mask;
    logic [1:0] next_mask;
    logic trip_prev;
    logic next_trip_prev;
    logic [7:0] next_rdata;
    logic next_irq;
    logic next_wake;
    logic enabled;
    logic stable;
    logic crossing;
    logic stable_rise;

    assign enabled = control[BIT_ENABLE];
    // Gated by enable so a disable hides the stable bit at once
    assign stable = (state == SVD_ARMED) && enabled;

    always_comb
    begin
        next_state = state;
        case (state)
            SVD_OFF:
            begin
                // Stale settled copy of the last enable must drain first
                if (enabled && !sig.settled)
                    next_state = SVD_SETTLING;
            end
            SVD_SETTLING:
            begin
                if (!enabled)
                    next_state = SVD_OFF;
                // Settling ends on the analog indication only
                else if (sig.settled)
                    next_state = SVD_ARMED;
            end
            SVD_ARMED:
            begin
                if (!enabled)
                    next_state = SVD_OFF;
            end
            default:
                next_state = SVD_OFF;
        endcase
    end

    // ==========================================================
    // Event detection
    // The comparator is taken as asserting while the supply sits on the
    // chosen side of the threshold; its polarity is set by the direction
    // output, so the rising edge of the synchronised level is the event.
    always_comb
    begin
        next_trip_prev = sig.trip;
        crossing = stable && sig.trip && !trip_prev;
        stable_rise = (state == SVD_SETTLING) && (next_state == SVD_ARMED);
    end

    // ==========================================================
    // Registers and read port
    always_comb
    begin
        next_control = control;
        next_mask = mask;
        next_flags = flags;
        next_rdata = 8'h00;
        if (reg_write && reg_addr == ADDR_CONTROL)
            next_control = reg_wdata & CONTROL_WMASK;
        if (reg_write && reg_addr == ADDR_MASK)
            next_mask = reg_wdata[1:0];
        if (reg_write && reg_addr == ADDR_FLAGS)
            next_flags = flags & ~reg_wdata[1:0];
        if (reg_read)
        begin
            case (reg_addr)
                ADDR_CONTROL:
                begin
                    next_rdata = control;
                    next_rdata[BIT_REF_STABLE] = stable;
                    next_rdata[BIT_UNUSED] = 1'b0;
                end
                ADDR_STATUS:
                    next_rdata = {6'h00, flags};
                ADDR_MASK:
                    next_rdata = {6'h00, mask};
                ADDR_FLAGS:
                    next_rdata = {6'h00, flags};
                default:
                    next_rdata = 8'h00;
            endcase
            // Status read clears the sticky bits
            if (reg_addr == ADDR_STATUS)
                next_flags = EVENT_NONE;
        end
        // Hardware set wins over any clear in the same cycle
        if (crossing)
            next_flags[BIT_DETECT] = 1'b1;
        if (stable_rise)
            next_flags[BIT_STABLE_EVT] = 1'b1;
        next_irq = |(next_flags & next_mask);
        // Wake does not depend on the mask so sleep exits on any crossing
        next_wake = next_flags[BIT_DETECT];
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state <= SVD_OFF;
            control <= CONTROL_RESET;
            mask <= EVENT_NONE;
            flags <= EVENT_NONE;
            trip_prev <= 1'b0;
            reg_rdata <= 8'h00;
            irq <= 1'b0;
            wake <= 1'b0;
            analog_power <= 1'b0;
            tap_select <= LEVEL_RESET;
            external_select <= 1'b0;
            direction_select <= 1'b0;
        end
        else
        begin
            state <= next_state;
            control <= next_control;
            mask <= next_mask;
            flags <= next_flags;
            trip_prev <= next_trip_prev;
            reg_rdata <= next_rdata;
            irq <= next_irq;
            wake <= next_wake;
            analog_power <= next_control[BIT_ENABLE];
            tap_select <= next_control[LEVEL_MSB:LEVEL_LSB];
            external_select <= (next_control[LEVEL_MSB:LEVEL_LSB] == LEVEL_EXTERNAL);
            direction_select <= next_control[BIT_DIRECTION];
        end
    end
endmodule

// ===== test/svd_analog_model.sv
// Behavioural reference, divider and comparator facing the detector block
`timescale 1ns/10ps
module svd_analog_model #(parameter int SETTLE_NS = 300)
(
    // From the block
    input wire logic analog_power,
    input wire logic [3:0] tap_select,
    input wire logic external_select,
    input wire logic direction_select,
    // Supply and pin levels in tap units
    input wire logic [3:0] supply,
    input wire logic [3:0] ext_level,
    // To the block
    output logic comparator_out,
    output logic reference_settled
);
    logic [3:0] trip;
    // Time based, so a clock change leaves it alone
    always
    begin
        reference_settled = 1'b0;
        wait (analog_power);
        // A power drop during settling restarts the interval
        fork
            #(SETTLE_NS);
            wait (!analog_power);
        join_any
        disable fork;
        reference_settled = analog_power;
        wait (!analog_power);
    end
    assign trip = external_select ? ext_level : tap_select;
    assign comparator_out = analog_power &&
        (direction_select ? supply >= trip : supply <= trip);
endmodule

// ===== test/svd_ctrl_assertions.sv
// Checker on the detector block ports, with its bind
`timescale 1ns/10ps
module svd_ctrl_assertions
    import svd_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // Analog side and events
    input wire logic comparator_out,
    input wire logic reference_settled,
    input wire logic analog_power,
    input wire logic [3:0] tap_select,
    input wire logic external_select,
    input wire logic direction_select,
    input wire logic wake,
    input wire logic irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic ctl_wr;
    logic ctl_rd;
    assign ctl_wr = reg_write && reg_addr == ADDR_CONTROL;
    assign ctl_rd = reg_read && reg_addr == ADDR_CONTROL;
    a_bit6_zero: assert property ($past(ctl_rd) |-> !reg_rdata[BIT_UNUSED])
        else $error("bit 6 read as one");
    a_power_write: assert property ($past(ctl_wr) |-> analog_power == $past(reg_wdata[4]))
        else $error("power does not follow enable");
    a_level_write: assert property ($past(ctl_wr) |-> tap_select == $past(reg_wdata[3:0]))
        else $error("tap does not follow level");
    a_dir_write: assert property ($past(ctl_wr) |-> direction_select == $past(reg_wdata[7]))
        else $error("direction does not follow bit 7");
    a_ext_route: assert property (external_select == (tap_select == LEVEL_EXTERNAL))
        else $error("external select wrong");
    a_stable_off: assert property ($past(ctl_rd) && !$past(analog_power)
        |-> !reg_rdata[BIT_REF_STABLE])
        else $error("stable bit set while off");
    a_wake_armed: assert property ($rose(wake) |-> $past(analog_power))
        else $error("flag set while off");
    a_flag_sticky: assert property (wake && !(reg_write && reg_addr == ADDR_FLAGS)
        && !(reg_read && reg_addr == ADDR_STATUS) |=> wake)
        else $error("flag cleared by itself");
    // Settled now and three samples back, so a stale level from a short
    // power drop cannot make a rise during settling look like an armed one
    a_trip_flag: assert property ($rose(comparator_out) && analog_power
        && reference_settled && $past(reference_settled, 3) |-> ##[1:5] wake)
        else $error("crossing missed");
    a_mask_quiet: assert property ($past(reg_write) && $past(reg_addr) == ADDR_MASK
        && $past(reg_wdata) == 8'h00 |-> !irq)
        else $error("irq with mask clear");
endmodule
bind svd_ctrl svd_ctrl_assertions i_svd_ctrl_assertions (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .comparator_out(comparator_out),
    .reference_settled(reference_settled), .analog_power(analog_power),
    .tap_select(tap_select), .external_select(external_select),
    .direction_select(direction_select), .wake(wake), .irq(irq));

// ===== test/test_svd_ctrl.sv
// Self-checking bench for the voltage detector control block
`timescale 1ns/10ps
module test_svd_ctrl
    import svd_pkg::*;
;
    logic clock, rst, reg_write, reg_read, comparator_out, reference_settled;
    logic analog_power, external_select, direction_select, wake, irq;
    logic [3:0] reg_addr, tap_select, supply, ext_level;
    logic [7:0] reg_wdata, reg_rdata;
    int num_errors = 0;
    int samples_checked = 0;
    logic [7:0] ctl [6] = '{8'h13, 8'h13, 8'h98, 8'h98, 8'h9F, 8'h08};
    logic [3:0] s0 [6] = '{4'h9, 4'h9, 4'h2, 4'h2, 4'h2, 4'h9};
    logic [3:0] s1 [6] = '{4'h3, 4'h4, 4'h8, 4'h7, 4'h5, 4'h1};
    logic det [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    svd_ctrl i_svd_ctrl (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .comparator_out(comparator_out),
        .reference_settled(reference_settled), .analog_power(analog_power),
        .tap_select(tap_select), .external_select(external_select),
        .direction_select(direction_select), .wake(wake), .irq(irq));
    svd_analog_model i_svd_analog_model (.analog_power(analog_power),
        .tap_select(tap_select), .external_select(external_select),
        .direction_select(direction_select), .supply(supply), .ext_level(ext_level),
        .comparator_out(comparator_out), .reference_settled(reference_settled));
    // ====
    // Tasks
    task automatic conclude();
        $display("Checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    // ====
    // Clock, watchdog and tests
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial
    begin
        #50000;
        num_errors++;
        conclude();
    end
    initial
    begin
        {rst, reg_write, reg_read, reg_addr, reg_wdata} = {3'b100, 12'h000};
        supply = 4'h9;
        ext_level = 4'h5;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        rd(ADDR_CONTROL, CONTROL_RESET);
        rd(4'h7, 8'h00);
        wr(4'h9, 8'hFF);
        rd(ADDR_CONTROL, CONTROL_RESET);
        wr(ADDR_CONTROL, 8'hFF);
        rd(ADDR_CONTROL, 8'h9F);
        chk({7'h00, external_select}, 8'h01);
        $display("Test registers done");
        // Dip during settling must be ignored
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_CONTROL, 8'h13);
        supply <= 4'h2;
        repeat (4) @(posedge clock);
        supply <= 4'h9;
        repeat (25) @(posedge clock);
        rd(ADDR_FLAGS, 8'h02);
        $display("Test settling done");
        for (int i = 0; i < 6; i++)
        begin
            wr(ADDR_CONTROL, 8'h00);
            supply <= s0[i];
            wr(ADDR_CONTROL, ctl[i]);
            rd(ADDR_CONTROL, ctl[i]);
            repeat (25) @(posedge clock);
            rd(ADDR_CONTROL, ctl[i] | {2'b00, ctl[i][4], 5'h00});
            wr(ADDR_FLAGS, 8'h03);
            supply <= s1[i];
            repeat (6) @(posedge clock);
            rd(ADDR_FLAGS, {7'h00, det[i]});
            chk({7'h00, wake}, {7'h00, det[i]});
            // Interrupt only unmasked once the reference is stable
            wr(ADDR_MASK, {7'h00, ctl[i][4]});
            chk({7'h00, irq}, {7'h00, det[i]});
            wr(ADDR_MASK, 8'h00);
            rd(ADDR_FLAGS, {7'h00, det[i]});
            rd(ADDR_STATUS, {7'h00, det[i]});
            rd(ADDR_FLAGS, 8'h00);
            $display("Test case %0d done", i);
        end
        wr(ADDR_CONTROL, 8'hFF);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        rd(ADDR_CONTROL, CONTROL_RESET);
        chk({7'h00, analog_power}, 8'h00);
        $display("Test reset done");
        conclude();
    end
endmodule
